// ### hdl/synth_core_map.vh
`ifndef SYNTH_CORE_MAP_VH
`define SYNTH_CORE_MAP_VH
// register addresses (4-bit address field, 12-bit data field)
`define ADDR_MAIN_DIVIDER   4'h0
`define ADDR_MAIN_DVD_MSB   4'h1
`define ADDR_MAIN_DVD_LSB   4'h2
`define ADDR_AUX_DIVIDER    4'h3
`define ADDR_AUX_DIVIDEND   4'h4
`define ADDR_REF_DIVIDERS   4'h5
`define ADDR_PUMP_CONTROL   4'h6
`define ADDR_POWER_DOWN     4'h7
`define ADDR_MUX_CONTROL    4'h8
`define ADDR_MODE_CONTROL   4'h9
`define REG_COUNT           10
`define FRAME_BITS          16
`define ADDR_MSB            15
`define ADDR_LSB            12
`define SHORT_FRAME_EDGES   5'd13
`define NREG_OFFSET         10'h020
`define NREG_MIN_FRAC       9'h006
`define NREG_MAX_FRAC       9'h1F9
// mode control fields
`define MODE_FRAC_BIT       0
`define MODE_18BIT_BIT      1
`define MODE_LOCKDET_BIT    2
// mux select codes
`define MUX_LOW             2'h0
`define MUX_SERIAL          2'h1
`define MUX_REF_MAIN        2'h2
`define MUX_REF_AUX         2'h3
// out-of-lock pulse timing in reference periods
`define LOCK_WINDOW_REFS    8'h10
`define LOCK_PULSE_REFS     8'h02
`endif

// ### hdl/config_regs.v
`include "synth_core_map.vh"
// ten 16-bit configuration words; read data registered
module config_regs #(
    parameter DEPTH = `REG_COUNT,
    parameter WIDTH = 16
) (
    input wire sys_clk,
    input wire reset,
    input wire wr_en,
    input wire [3:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [3:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    integer i;

    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem[i] <= {WIDTH{1'b0}};
            rd_data <= {WIDTH{1'b0}};
        end
        else
        begin
            if (wr_en && wr_addr < DEPTH)
                mem[wr_addr] <= wr_data;
            rd_data <= (rd_addr < DEPTH) ? mem[rd_addr] : {WIDTH{1'b0}};
        end
    end
endmodule

// ### hdl/synth_digital_core.v
// Summary of operation
// - three-wire port: clock, data, active-low select
// - received serial data looped back on mux
// - ten sixteen-bit configuration registers written serially
// - main modulator 10 or 18 bits; aux 10
// - modulator output plus integer ratio gives divide
// - divide 38..537 fractional, 32..543 integer
// - reference dividers 1..32, main and aux
// - crystal clock drives the reference dividers
// - per-loop detector gain, 32 steps
// - shared pin: steering or lock indication
// - lock mode uses internal steering instead
// - out of lock: low pulses; locked: released
// - power-down modes selected by serial writes
// - sample data on each serial clock rise
// - sixteen bits, LSB last; keep last sixteen
// - select rises before edge 13: modulation data
// - new fractional ratio applies on last dividend
`include "synth_core_map.vh"
module synth_digital_core #(
    parameter MOD_WIDTH = 12
) (
    input wire sys_clk,
    input wire reset,
    input wire ser_clk,
    input wire ser_data,
    input wire ser_cs_n,
    input wire xtal_clk,
    input wire main_vco_edge,
    input wire main_ref_early,
    input wire main_locked_raw,
    output reg mux_out,
    output reg main_ref_tick,
    output reg aux_ref_tick,
    output reg [9:0] main_divide,
    output reg [9:0] aux_divide,
    output reg [17:0] main_frac,
    output reg [MOD_WIDTH-1:0] mod_data,
    output reg mod_strobe,
    output reg [4:0] main_detector_gain,
    output reg [4:0] aux_detector_gain,
    output reg [3:0] power_down,
    output reg internal_steer_en,
    output reg steer_up,
    output reg steer_down,
    output reg lock_or_steer_out_o,
    output reg lock_or_steer_out_oe_n
);
    // serial inputs are synchronous samples; edges detected in sys_clk
    reg sclk_q, cs_q, xclk_q;
    reg [15:0] shift_q;
    reg [4:0] edges_q;
    reg [15:0] ctrl_main_q, ctrl_aux_q, ctrl_ref_q, ctrl_pump_q, ctrl_pd_q, ctrl_mux_q, ctrl_mode_q;
    reg [15:0] pend_div_q, pend_aux_q, lsb_q;
    reg wr_q;
    reg [15:0] wr_data_q;
    reg [4:0] main_cnt_q, aux_cnt_q;
    reg [7:0] win_cnt_q, pulse_cnt_q;
    reg unlocked_q;
    wire [15:0] rd_unused;

    wire sclk_rise = ser_clk & ~sclk_q;
    wire sclk_fall = ~ser_clk & sclk_q;
    wire cs_rise = ser_cs_n & ~cs_q;
    wire xclk_rise = xtal_clk & ~xclk_q;
    wire [3:0] addr = shift_q[`ADDR_MSB:`ADDR_LSB];
    wire frac_mode = ctrl_mode_q[`MODE_FRAC_BIT];
    wire mode18 = ctrl_mode_q[`MODE_18BIT_BIT];
    wire lock_mode = ctrl_mode_q[`MODE_LOCKDET_BIT];

    function [9:0] clamp_div;
        input [8:0] nreg;
        input frac;
        reg [8:0] n;
        begin
            n = nreg;
            if (frac && n < `NREG_MIN_FRAC)
                n = `NREG_MIN_FRAC;
            if (frac && n > `NREG_MAX_FRAC)
                n = `NREG_MAX_FRAC;
            clamp_div = {1'b0, n} + `NREG_OFFSET;
        end
    endfunction

    config_regs #(.DEPTH(`REG_COUNT), .WIDTH(16)) u_regs (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(wr_q),
        .wr_addr(wr_data_q[`ADDR_MSB:`ADDR_LSB]),
        .wr_data(wr_data_q),
        .rd_addr(4'h0),
        .rd_data(rd_unused)
    );

    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            shift_q <= 16'h0000;
            edges_q <= 5'd0;
            mod_data <= {MOD_WIDTH{1'b0}};
            mod_strobe <= 1'b0;
            wr_q <= 1'b0;
            wr_data_q <= 16'h0000;
        end
        else
        begin
            sclk_q <= ser_clk;
            cs_q <= ser_cs_n;
            mod_strobe <= 1'b0;
            wr_q <= 1'b0;
            if (!ser_cs_n && sclk_rise)
            begin
                shift_q <= {shift_q[14:0], ser_data};
                if (edges_q != 5'd31)
                    edges_q <= edges_q + 5'd1;
            end
            if (cs_rise)
            begin
                edges_q <= 5'd0;
                if (edges_q < `SHORT_FRAME_EDGES)
                begin
                    mod_data <= shift_q[MOD_WIDTH-1:0];
                    mod_strobe <= 1'b1;
                end
                else
                begin
                    wr_q <= 1'b1;
                    wr_data_q <= shift_q;
                end
            end
        end
    end

    // register decode and divide-ratio staging
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_ref_q <= 16'h0000;
            ctrl_pump_q <= 16'h0000;
            ctrl_pd_q <= 16'h0000;
            ctrl_mux_q <= 16'h0000;
            ctrl_mode_q <= 16'h0000;
            pend_div_q <= 16'h0000;
            pend_aux_q <= 16'h0000;
            lsb_q <= 16'h0000;
            main_divide <= `NREG_OFFSET;
            aux_divide <= `NREG_OFFSET;
            main_frac <= 18'h0_0000;
        end
        else if (wr_q)
        begin
            if (wr_data_q[`ADDR_MSB:`ADDR_LSB] == `ADDR_MAIN_DIVIDER)
            begin
                pend_div_q <= wr_data_q;
                if (!frac_mode)
                    main_divide <= clamp_div(wr_data_q[8:0], 1'b0);
            end
            else if (wr_data_q[`ADDR_MSB:`ADDR_LSB] == `ADDR_MAIN_DVD_LSB)
                lsb_q <= wr_data_q;
            else if (wr_data_q[`ADDR_MSB:`ADDR_LSB] == `ADDR_MAIN_DVD_MSB)
            begin
                main_divide <= clamp_div(pend_div_q[8:0], frac_mode);
                main_frac <= mode18 ? {wr_data_q[9:0], lsb_q[7:0]}
                                    : {{8{wr_data_q[9]}}, wr_data_q[9:0]};
            end
            else if (wr_data_q[`ADDR_MSB:`ADDR_LSB] == `ADDR_AUX_DIVIDER)
            begin
                pend_aux_q <= wr_data_q;
                if (!frac_mode)
                    aux_divide <= clamp_div(wr_data_q[8:0], 1'b0);
            end
            else if (wr_data_q[`ADDR_MSB:`ADDR_LSB] == `ADDR_AUX_DIVIDEND)
                aux_divide <= clamp_div(pend_aux_q[8:0], frac_mode);
            else if (wr_data_q[`ADDR_MSB:`ADDR_LSB] == `ADDR_REF_DIVIDERS)
                ctrl_ref_q <= wr_data_q;
            else if (wr_data_q[`ADDR_MSB:`ADDR_LSB] == `ADDR_PUMP_CONTROL)
                ctrl_pump_q <= wr_data_q;
            else if (wr_data_q[`ADDR_MSB:`ADDR_LSB] == `ADDR_POWER_DOWN)
                ctrl_pd_q <= wr_data_q;
            else if (wr_data_q[`ADDR_MSB:`ADDR_LSB] == `ADDR_MUX_CONTROL)
                ctrl_mux_q <= wr_data_q;
            else if (wr_data_q[`ADDR_MSB:`ADDR_LSB] == `ADDR_MODE_CONTROL)
                ctrl_mode_q <= wr_data_q;
        end
    end

    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            main_detector_gain <= 5'd0;
            aux_detector_gain <= 5'd0;
            power_down <= 4'h0;
            internal_steer_en <= 1'b0;
        end
        else
        begin
            main_detector_gain <= ctrl_pump_q[4:0];
            aux_detector_gain <= ctrl_pump_q[9:5];
            power_down <= ctrl_pd_q[3:0];
            internal_steer_en <= lock_mode;
        end
    end

    // reference dividers run off crystal edges; ratio field value+1 gives 1..32
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            xclk_q <= 1'b0;
            main_cnt_q <= 5'd0;
            aux_cnt_q <= 5'd0;
            main_ref_tick <= 1'b0;
            aux_ref_tick <= 1'b0;
        end
        else
        begin
            xclk_q <= xtal_clk;
            main_ref_tick <= 1'b0;
            aux_ref_tick <= 1'b0;
            if (xclk_rise)
            begin
                main_cnt_q <= (main_cnt_q >= ctrl_ref_q[4:0]) ? 5'd0 : main_cnt_q + 5'd1;
                aux_cnt_q <= (aux_cnt_q >= ctrl_ref_q[9:5]) ? 5'd0 : aux_cnt_q + 5'd1;
                main_ref_tick <= (main_cnt_q >= ctrl_ref_q[4:0]);
                aux_ref_tick <= (aux_cnt_q >= ctrl_ref_q[9:5]);
            end
        end
    end

    // lock detect: a window of reference periods; any miss restarts it
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            win_cnt_q <= 8'h00;
            pulse_cnt_q <= 8'h00;
            unlocked_q <= 1'b1;
            steer_up <= 1'b0;
            steer_down <= 1'b0;
            lock_or_steer_out_o <= 1'b0;
            lock_or_steer_out_oe_n <= 1'b1;
            mux_out <= 1'b0;
        end
        else
        begin
            if (main_ref_tick)
            begin
                if (!main_locked_raw)
                begin
                    win_cnt_q <= 8'h00;
                    unlocked_q <= 1'b1;
                end
                else if (win_cnt_q == `LOCK_WINDOW_REFS)
                    unlocked_q <= 1'b0;
                else
                    win_cnt_q <= win_cnt_q + 8'h01;
                pulse_cnt_q <= (pulse_cnt_q == `LOCK_PULSE_REFS) ? 8'h00 : pulse_cnt_q + 8'h01;
            end
            // internal steering only in lock-detect mode; otherwise the pin does the steering
            steer_up <= lock_mode & ~main_locked_raw & main_ref_early;
            steer_down <= lock_mode & ~main_locked_raw & ~main_ref_early & main_vco_edge;
            lock_or_steer_out_o <= 1'b0;
            if (lock_mode)
                // pulse low only in the first reference period of each cycle
                lock_or_steer_out_oe_n <= ~(unlocked_q && pulse_cnt_q == 8'h00);
            else
            begin
                lock_or_steer_out_o <= ~main_locked_raw & main_ref_early;
                lock_or_steer_out_oe_n <= main_locked_raw;
            end
            if (sclk_fall || ctrl_mux_q[1:0] != `MUX_SERIAL)
            begin
                if (ctrl_mux_q[1:0] == `MUX_SERIAL)
                    mux_out <= shift_q[15];
                else if (ctrl_mux_q[1:0] == `MUX_REF_MAIN)
                    mux_out <= main_ref_tick;
                else if (ctrl_mux_q[1:0] == `MUX_REF_AUX)
                    mux_out <= aux_ref_tick;
                else
                    mux_out <= 1'b0;
            end
        end
    end
endmodule

// ### test/host_model.sv
module host_model (
    input wire sys_clk,
    output logic ser_clk,
    output logic ser_data,
    output logic ser_cs_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        ser_clk = 0;
        ser_data = 0;
        ser_cs_n = 1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // msb first, one bit per serial rise, each phase two system cycles
    task automatic send(input logic [19:0] w, input int n);
        ser_cs_n = 0;
        for (int i = n - 1; i >= 0; i--)
        begin
            ser_data = w[i];
            tick(2);
            ser_clk = 1;
            tick(2);
            ser_clk = 0;
        end
        tick(2);
        // released data line must not keep a stale level
        ser_data = ~ser_data;
        ser_cs_n = 1;
        tick(2);
    endtask
endmodule

// ### test/synth_core_props.sv
module synth_core_props #(
    parameter MOD_WIDTH = 12
) (
    input wire sys_clk,
    input wire reset,
    input wire ser_cs_n,
    input wire mod_strobe,
    input wire [MOD_WIDTH-1:0] mod_data,
    input wire main_ref_tick,
    input wire [9:0] main_divide,
    input wire [4:0] main_detector_gain,
    input wire [3:0] power_down,
    input wire internal_steer_en,
    input wire steer_up,
    input wire steer_down,
    input wire lock_or_steer_out_o,
    input wire lock_or_steer_out_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    strobe_pulse_a: assert property (mod_strobe |=> !mod_strobe) else $error("strobe wide");
    strobe_cs_a: assert property (mod_strobe |-> ser_cs_n) else $error("strobe in frame");
    mod_hold_a: assert property ($changed(mod_data) |-> mod_strobe) else $error("mod data moved");
    divide_range_a: assert property (main_divide >= 10'h020 && main_divide <= 10'h21F) else $error("bad divide");
    divide_hold_a: assert property ($changed(main_divide) |-> ser_cs_n) else $error("divide in frame");
    gain_hold_a: assert property ($changed(main_detector_gain) |-> ser_cs_n) else $error("gain in frame");
    power_hold_a: assert property ($changed(power_down) |-> ser_cs_n) else $error("power in frame");
    ref_pulse_a: assert property (main_ref_tick |=> !main_ref_tick) else $error("tick wide");
    pin_low_a: assert property (!lock_or_steer_out_oe_n && internal_steer_en |-> !lock_or_steer_out_o)
        else $error("pin driven high");
    steer_mode_a: assert property (steer_up || steer_down |-> internal_steer_en || $past(internal_steer_en))
        else $error("steer off mode");
    cover property (mod_strobe);
    cover property (main_ref_tick);
    cover property (!lock_or_steer_out_oe_n);
endmodule

// ### test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, reset = 1, xtal_clk = 0, main_locked_raw = 1, seen = 0;
    logic main_vco_edge = 0, main_ref_early = 0;
    wire ser_clk, ser_data, ser_cs_n, mux_out, main_ref_tick, aux_ref_tick, mod_strobe;
    wire internal_steer_en, steer_up, steer_down, lock_or_steer_out_o, lock_or_steer_out_oe_n;
    wire [9:0] main_divide, aux_divide;
    wire [17:0] main_frac;
    wire [11:0] mod_data;
    wire [4:0] main_detector_gain, aux_detector_gain;
    wire [3:0] power_down;
    int errors = 0, num_checks = 0, strobes = 0;
    always #2 sys_clk = ~sys_clk;
    always
    begin
        repeat (3) @(posedge sys_clk);
        #1 xtal_clk = ~xtal_clk;
    end
    always @(posedge sys_clk)
    begin
        strobes <= strobes + mod_strobe;
        if (mux_out === 1'b1) seen <= 1;
    end
    host_model host_u (.sys_clk(sys_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_cs_n(ser_cs_n));
    synth_digital_core #(.MOD_WIDTH(12)) dut_u (.sys_clk(sys_clk), .reset(reset), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_cs_n(ser_cs_n), .xtal_clk(xtal_clk), .main_vco_edge(main_vco_edge),
        .main_ref_early(main_ref_early), .main_locked_raw(main_locked_raw), .mux_out(mux_out),
        .main_ref_tick(main_ref_tick), .aux_ref_tick(aux_ref_tick), .main_divide(main_divide),
        .aux_divide(aux_divide), .main_frac(main_frac), .mod_data(mod_data), .mod_strobe(mod_strobe),
        .main_detector_gain(main_detector_gain), .aux_detector_gain(aux_detector_gain),
        .power_down(power_down), .internal_steer_en(internal_steer_en), .steer_up(steer_up),
        .steer_down(steer_down), .lock_or_steer_out_o(lock_or_steer_out_o),
        .lock_or_steer_out_oe_n(lock_or_steer_out_oe_n));
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        host_u.send({4'h0, a, d}, 16);
        host_u.tick(6);
    endtask
    task automatic t_int;
        wr(4'h0, 12'h00D);
        chk(main_divide, 10'h02D);
        wr(4'h3, 12'h1FF);
        chk(aux_divide, 10'h21F);
        $display("t_int done");
    endtask
    task automatic t_frac;
        wr(4'h9, 12'h003);
        wr(4'h0, 12'h014);
        chk(main_divide, 10'h02D);
        wr(4'h2, 12'h098);
        wr(4'h1, 12'h07D);
        chk(main_divide, 10'h034);
        chk(main_frac, 18'h0_7D98);
        wr(4'h9, 12'h001);
        wr(4'h0, 12'h001);
        wr(4'h1, 12'h3FF);
        chk(main_frac, 18'h3_FFFF);
        chk(main_divide, 10'h026);
        wr(4'h3, 12'h003);
        chk(aux_divide, 10'h21F);
        wr(4'h4, 12'h001);
        chk(aux_divide, 10'h026);
        $display("t_frac done");
    endtask
    task automatic t_reg;
        wr(4'h6, 12'h3EA);
        chk({aux_detector_gain, main_detector_gain}, 10'h3EA);
        wr(4'h7, 12'h00F);
        chk(power_down, 4'hF);
        host_u.send({4'hF, 4'h6, 12'h155}, 20);
        host_u.tick(6);
        chk({aux_detector_gain, main_detector_gain}, 10'h155);
        wr(4'hA, 12'h000);
        chk(main_detector_gain, 5'h15);
        chk(strobes, 0);
        $display("t_reg done");
    endtask
    task automatic t_mod;
        host_u.send({8'h00, 12'hABC}, 12);
        host_u.tick(2);
        chk(strobes, 1);
        chk(mod_data, 12'hABC);
        $display("t_mod done");
    endtask
    task automatic t_ref;
        int m = 0, x = 0;
        wr(4'h5, 12'h3E3);
        repeat (384)
        begin
            host_u.tick(1);
            m += main_ref_tick;
            x += aux_ref_tick;
        end
        // dividers free-run, so phase at the window edges may cost one tick
        chk(m >= 15 && m <= 17, 1);
        chk(x >= 1 && x <= 3, 1);
        $display("t_ref done");
    endtask
    task automatic t_loop;
        seen = 0;
        host_u.send({4'h0, 16'hFFFF}, 16);
        chk(seen, 0);
        wr(4'h8, 12'h001);
        seen = 0;
        host_u.send({4'h0, 16'hFFFF}, 16);
        chk(seen, 1);
        wr(4'h8, 12'h002);
        seen = 0;
        host_u.tick(60);
        chk(seen, 1);
        wr(4'h8, 12'h003);
        seen = 0;
        host_u.tick(200);
        chk(seen, 1);
        $display("t_loop done");
    endtask
    task automatic t_lock;
        int n = 0;
        wr(4'h9, 12'h004);
        chk(internal_steer_en, 1);
        main_locked_raw = 0;
        while (lock_or_steer_out_oe_n !== 1'b0 && n < 4000)
        begin
            host_u.tick(1);
            n++;
        end
        chk(lock_or_steer_out_oe_n, 0);
        chk(lock_or_steer_out_o, 0);
        main_locked_raw = 1;
        host_u.tick(3000);
        n = 0;
        repeat (300)
        begin
            host_u.tick(1);
            n += !lock_or_steer_out_oe_n;
        end
        chk(n, 0);
        wr(4'h9, 12'h000);
        chk(internal_steer_en, 0);
        $display("t_lock done");
    endtask
    task automatic t_steer;
        main_locked_raw = 0;
        main_ref_early = 1;
        host_u.tick(2);
        chk({lock_or_steer_out_oe_n, lock_or_steer_out_o}, 2'h1);
        chk({steer_up, steer_down}, 2'h0);
        wr(4'h9, 12'h004);
        chk({steer_up, lock_or_steer_out_o}, 2'h2);
        main_ref_early = 0;
        main_vco_edge = 1;
        host_u.tick(2);
        chk({steer_up, steer_down}, 2'h1);
        main_locked_raw = 1;
        main_vco_edge = 0;
        host_u.tick(2);
        chk({steer_up, steer_down}, 2'h0);
        $display("t_steer done");
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #200000;
        errors++;
        report_and_stop();
    end
    initial
    begin
        host_u.tick(4);
        reset = 0;
        host_u.tick(2);
        t_int();
        t_frac();
        t_reg();
        t_mod();
        t_ref();
        t_loop();
        t_lock();
        t_steer();
        report_and_stop();
    end
endmodule
bind synth_digital_core synth_core_props #(.MOD_WIDTH(MOD_WIDTH)) props_u (.sys_clk(sys_clk), .reset(reset),
    .ser_cs_n(ser_cs_n), .mod_strobe(mod_strobe), .mod_data(mod_data), .main_ref_tick(main_ref_tick),
    .main_divide(main_divide), .main_detector_gain(main_detector_gain), .power_down(power_down),
    .internal_steer_en(internal_steer_en), .steer_up(steer_up), .steer_down(steer_down),
    .lock_or_steer_out_o(lock_or_steer_out_o), .lock_or_steer_out_oe_n(lock_or_steer_out_oe_n));
